/* cvd_defs.svh */
// Purpose: constants for the cvd double sample control block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes:   register bit layout and bus offsets
`ifndef CVD_DEFS_SVH
`define CVD_DEFS_SVH

`define CVD_CTRL3_OFFSET   8'h00
`define CVD_CORE_OFFSET    8'h04
`define CVD_ADDR_W         8
`define CVD_BIT_EXT_POL    7
`define CVD_BIT_INT_POL    6
`define CVD_BIT_INV_EN     1
`define CVD_BIT_DS_EN      0
`define CVD_BIT_GO         0
`define CVD_BIT_GUARD      1
`define CVD_BIT_SECOND     2
`define CVD_WORD_MASK      8'hFC
`define CVD_CTRL3_MASK     8'hC3
`define CVD_CTRL3_RESET    8'h00
`define CVD_RESP_OKAY      2'h0
`define CVD_RESP_SLVERR    2'h2

`endif

/* cvd_double_sample_control.sv */
// Purpose: axi4-lite register and sequencing for one cvd converter
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes:   core register at 0x04 holds the go flag and guard polarity
// Notes on behaviour
// [RQ1] double sample on: restart right after completion
// [RQ2] double sample off: one conversion per request
// [RQ3] invert second conversion polarities when enabled
// [RQ4] bits five to two read zero
// [RQ5] implemented bits read/write, reset to zero
// [RQ6] inversion on outputs only, stored bits unchanged
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "cvd_defs.svh"

module cvd_double_sample_control
   import cvd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        conv_done,       // from converter core
   output logic             conv_start,      // pulse to converter core
   output logic             second_conversion,
   output logic             external_precharge_polarity,
   output logic             internal_precharge_polarity,
   output logic             guard_ring_polarity
);
   // stored control bits
   logic [7:0]  ctrl3_q, ctrl3_d;
   logic        guard_q, guard_d;     // stored guard ring polarity
   logic        go_q, go_d;           // conversion_go_flag
   // bus channel state
   logic        aw_have_q, aw_have_d;
   logic [7:0]  aw_addr_q, aw_addr_d;
   logic        w_have_q, w_have_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0]  w_strb_q, w_strb_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   // sequencer wires
   logic        seq_start, seq_busy;
   cvd_pol_t    pol_stored, pol_drv;
   logic        wr_fire, go_set;
   logic        done_seen_q, done_seen_d; // go flag already served

   assign pol_stored.external_precharge_polarity = ctrl3_q[`CVD_BIT_EXT_POL];
   assign pol_stored.internal_precharge_polarity = ctrl3_q[`CVD_BIT_INT_POL];
   assign pol_stored.guard_ring_polarity         = guard_q;

   // one address and one data held each; taken in either order
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

   // write path and stored register next values
   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d  = w_have_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      ctrl3_d   = ctrl3_q;
      guard_d   = guard_q;
      go_set    = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = `CVD_RESP_OKAY;
         case (aw_addr_q & `CVD_WORD_MASK)
            `CVD_CTRL3_OFFSET: begin
               if (w_strb_q[0]) begin
                  // unimplemented bits dropped on write
                  ctrl3_d = w_data_q[7:0] & `CVD_CTRL3_MASK; // [RQ4] [RQ5]
               end
            end
            `CVD_CORE_OFFSET: begin
               if (w_strb_q[0]) begin
                  guard_d = w_data_q[`CVD_BIT_GUARD];
                  go_set  = w_data_q[`CVD_BIT_GO];
               end
            end
            default: begin
               bresp_d = `CVD_RESP_SLVERR;
            end
         endcase
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // go flag: set by software, cleared by hardware at end of sequence
   // writing zero cannot abort a running pair; set wins over clear
   always_comb begin
      go_d = go_q;
      if (go_q && !seq_busy && !seq_start) begin
         go_d = 1'b0;
      end
      if (go_set) begin
         go_d = 1'b1;
      end
   end
   assign seq_start = go_q && !seq_busy && !done_seen_q;

   // guards against restarting from a go flag already served
   always_comb begin
      done_seen_d = done_seen_q;
      if (seq_busy) begin
         done_seen_d = 1'b1;
      end else if (done_seen_q) begin
         done_seen_d = 1'b0;
      end
   end

   // read path; stored bits read as written, never inverted
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = `CVD_RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         case (s_axi_araddr & `CVD_WORD_MASK)
            `CVD_CTRL3_OFFSET: begin
               rdata_d[7:0] = ctrl3_q & `CVD_CTRL3_MASK; // [RQ4] [RQ6]
            end
            `CVD_CORE_OFFSET: begin
               rdata_d[`CVD_BIT_SECOND] = second_conversion;
               rdata_d[`CVD_BIT_GUARD]  = guard_q;
               rdata_d[`CVD_BIT_GO]     = go_q;
            end
            default: begin
               rresp_d = `CVD_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // all state registers; everything clears on any reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl3_q     <= `CVD_CTRL3_RESET; // [RQ5]
         guard_q     <= 1'b0;
         go_q        <= 1'b0;
         done_seen_q <= 1'b0;
         aw_have_q   <= 1'b0;
         aw_addr_q   <= 8'h00;
         w_have_q    <= 1'b0;
         w_data_q    <= 32'h0000_0000;
         w_strb_q    <= 4'h0;
         bvalid_q    <= 1'b0;
         bresp_q     <= 2'h0;
         rvalid_q    <= 1'b0;
         rdata_q     <= 32'h0000_0000;
         rresp_q     <= 2'h0;
      end else begin
         ctrl3_q     <= ctrl3_d;
         guard_q     <= guard_d;
         go_q        <= go_d;
         done_seen_q <= done_seen_d;
         aw_have_q   <= aw_have_d;
         aw_addr_q   <= aw_addr_d;
         w_have_q    <= w_have_d;
         w_data_q    <= w_data_d;
         w_strb_q    <= w_strb_d;
         bvalid_q    <= bvalid_d;
         bresp_q     <= bresp_d;
         rvalid_q    <= rvalid_d;
         rdata_q     <= rdata_d;
         rresp_q     <= rresp_d;
      end
   end

   // pairing and polarity inversion
   cvd_sequencer u_seq (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .start_in               (seq_start),
      .conv_done_in           (conv_done),
      .double_sample_enable   (ctrl3_q[`CVD_BIT_DS_EN]),   // [RQ1] [RQ2]
      .invert_polarity_enable (ctrl3_q[`CVD_BIT_INV_EN]),  // [RQ3]
      .pol_stored             (pol_stored),
      .conv_start_out         (conv_start),
      .second_conv            (second_conversion),
      .busy                   (seq_busy),
      .pol_out                (pol_drv)
   );

   assign external_precharge_polarity = pol_drv.external_precharge_polarity; // [RQ6]
   assign internal_precharge_polarity = pol_drv.internal_precharge_polarity;
   assign guard_ring_polarity         = pol_drv.guard_ring_polarity;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
endmodule

/* cvd_dsc_chk.sv */
// Purpose: port assertions for cvd double sample control
// Assumes: one clock, sync active-low reset
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
`include "cvd_defs.svh"
module cvd_dsc_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        conv_done,
   input wire logic        conv_start,
   input wire logic        second_conversion,
   input wire logic        external_precharge_polarity,
   input wire logic        internal_precharge_polarity,
   input wire logic        guard_ring_polarity
);
   logic [2:0] pol;         // front end bundle {ext, int, guard}
   logic [2:0] pol_first_q; // bundle seen at a first start
   logic [2:0] pol_first_d;
   logic [7:0] rd_addr_q;   // address of the read in flight
   logic [7:0] rd_addr_d;
   assign pol = {external_precharge_polarity, internal_precharge_polarity, guard_ring_polarity};
   // next values of helper state
   always_comb begin
      pol_first_d = pol_first_q;
      rd_addr_d   = rd_addr_q;
      if (conv_start && !second_conversion) begin
         pol_first_d = pol;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_d = s_axi_araddr;
      end
   end
   // cleared on reset so a mid-pair reset leaves no stale capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pol_first_q <= 3'h0;
         rd_addr_q   <= 8'h00;
      end else begin
         pol_first_q <= pol_first_d;
         rd_addr_q   <= rd_addr_d;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   restart_after_done_a: assert property ($rose(second_conversion) |-> conv_start && $past(conv_done))
      else $error("second start not right after done");
   pair_ends_a: assert property (second_conversion && conv_done |=> !second_conversion && !conv_start)
      else $error("conversion after end of pair");
   pol_uniform_a: assert property ($rose(second_conversion) |-> pol == $past(pol) || pol == ~$past(pol))
      else $error("polarities not flipped together");
   pol_restore_a: assert property ($fell(second_conversion) |-> pol == pol_first_q)
      else $error("polarities not restored after pair");
   rd_reserved_a: assert property (s_axi_rvalid && rd_addr_q == `CVD_CTRL3_OFFSET
      && s_axi_rresp == `CVD_RESP_OKAY |-> (s_axi_rdata & ~{24'h0, `CVD_CTRL3_MASK}) == 32'h0)
      else $error("unimplemented bits read nonzero");
   reset_clear_a: assert property (disable iff (1'h0) !aresetn |=> !conv_start && !second_conversion
      && pol == 3'h0)
      else $error("outputs not cleared by reset");
   cover property ($rose(second_conversion));
   cover property (conv_start && !second_conversion);
   cover property (s_axi_rvalid && s_axi_rresp == `CVD_RESP_SLVERR);
endmodule
bind cvd_double_sample_control cvd_dsc_chk i_chk (.*);

/* cvd_pkg.sv */
// Purpose: shared types for the cvd double sample control block
// Assumes: nothing included; widths are fixed in this file
// Notes:   polarity bundle travels as a packed struct
package cvd_pkg;
   // polarity values driven to the analog front end
   typedef struct packed {
      logic external_precharge_polarity;
      logic internal_precharge_polarity;
      logic guard_ring_polarity;
   } cvd_pol_t;

   // conversion sequencer states
   typedef enum logic [1:0] {
      CVD_IDLE,
      CVD_FIRST,
      CVD_SECOND
   } cvd_seq_t;
endpackage

/* cvd_sequencer.sv */
// Purpose: pairs conversions and flips polarity for the second one
// Assumes: core pulses conv_start_out accepted, conv_done_in one cycle
// Notes:   stored bits are never touched here, only outputs
`timescale 1ns/1ps
`include "cvd_defs.svh"

module cvd_sequencer
   import cvd_pkg::*;
(
   input  wire logic     aclk,
   input  wire logic     aresetn,
   input  wire logic     start_in,        // start request from go flag
   input  wire logic     conv_done_in,    // core finished one conversion
   input  wire logic     double_sample_enable,
   input  wire logic     invert_polarity_enable,
   input  wire cvd_pol_t pol_stored,      // polarities as stored
   output logic          conv_start_out,  // pulse to core
   output logic          second_conv,     // second of a pair running
   output logic          busy,            // a request is in progress
   output cvd_pol_t      pol_out          // polarities to front end
);
   cvd_seq_t st_q, st_d;   // sequencer state
   logic     start_q, start_d;
   logic     ds_q, ds_d;   // mode latched at request, stable across pair
   cvd_pol_t pol_q, pol_d;

   // next state
   always_comb begin
      st_d    = st_q;
      start_d = 1'b0;
      ds_d    = ds_q;
      pol_d   = pol_stored;
      case (st_q)
         CVD_IDLE: begin
            if (start_in) begin
               st_d    = CVD_FIRST;
               start_d = 1'b1;
               ds_d    = double_sample_enable;
            end
         end
         CVD_FIRST: begin
            if (conv_done_in) begin
               if (ds_q) begin
                  // restart at once, no software round trip
                  st_d    = CVD_SECOND; // [RQ1]
                  start_d = 1'b1;
               end else begin
                  st_d = CVD_IDLE; // [RQ2]
               end
            end
         end
         CVD_SECOND: begin
            if (conv_done_in) begin
               st_d = CVD_IDLE;
            end
         end
         default: begin
            st_d = CVD_IDLE;
         end
      endcase
      // inversion keyed on the next state, so it rises and falls with
      // second_conv; keyed on the current state the flipped values
      // would stand one cycle into idle
      if (st_d == CVD_SECOND && ds_d && invert_polarity_enable) begin
         pol_d = ~pol_stored; // [RQ3] [RQ6]
      end
   end

   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q    <= CVD_IDLE;
         start_q <= 1'b0;
         ds_q    <= 1'b0;
         pol_q   <= '0;
      end else begin
         st_q    <= st_d;
         start_q <= start_d;
         ds_q    <= ds_d;
         pol_q   <= pol_d;
      end
   end

   assign conv_start_out = start_q;
   assign second_conv    = (st_q == CVD_SECOND);
   assign busy           = (st_q != CVD_IDLE);
   assign pol_out        = pol_q;
endmodule

/* tb_cvd.sv */
// Purpose: directed bench for cvd double sample control
// Assumes: bench is axi4-lite master and converter core
// Notes:   polarity bundle compared as {ext, int, guard}
`timescale 1ns/1ps
`include "cvd_defs.svh"
module tb;
   logic        aclk = 1'h0, aresetn = 1'h0, conv_done = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0; // ignored by the block
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h1;                      // only lane zero is used
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        conv_start, second_conversion;
   logic        external_precharge_polarity, internal_precharge_polarity, guard_ring_polarity;
   int          err_count = 0, total_checks = 0;
   always #5 aclk = ~aclk; // 100 MHz
   cvd_double_sample_control i_dut (.*);
   task results;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // a used-up bound ends the run
   task tmo(input int i);
      if (i >= 50) begin
         err_count++;
         $display("[ERR] timeout expected 0 seen %0d", i);
         results();
      end
   endtask
   // write: both channels offered together, each dropped once taken
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      logic aw, w, b;
      logic [1:0] rs;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         #1;
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
         if (b) break;
      end
      s_axi_bready <= 1'h0;
      tmo(i);
      chk("bresp", {30'h0, r}, {30'h0, rs});
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int i;
      logic ar, rv;
      logic [31:0] dt;
      logic [1:0] rs;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         #1;
         ar = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid;
         dt = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'h0;
         if (rv) break;
      end
      s_axi_rready <= 1'h0;
      tmo(i);
      chk("rresp", {30'h0, r}, {30'h0, rs});
      chk("rdata", e, dt);
   endtask
   task pchk(input logic [2:0] p, input logic s);
      chk("pol", {29'h0, p}, {29'h0, external_precharge_polarity, internal_precharge_polarity, guard_ring_polarity});
      chk("second", {31'h0, s}, {31'h0, second_conversion});
   endtask
   // one conversion finishing, played as the core
   task done_pulse;
      @(posedge aclk);
      conv_done <= 1'h1;
      @(posedge aclk);
      conv_done <= 1'h0;
      #1;
   endtask
   // one start request; two says whether a pair is expected
   task conv(input logic two, input logic g, input logic [2:0] p1, input logic [2:0] p2, input logic [7:0] c);
      int i;
      wr(`CVD_CORE_OFFSET, {30'h0, g, 1'h1}, `CVD_RESP_OKAY);
      // the start pulse already stands in the cycle the write response ends
      for (i = 0; i < 50; i++) begin
         #1;
         if (conv_start === 1'h1) break;
         @(posedge aclk);
      end
      tmo(i);
      pchk(p1, 1'h0);
      done_pulse();
      chk("restart", {31'h0, two}, {31'h0, conv_start});
      if (two) begin
         pchk(p2, 1'h1);
         rd(`CVD_CTRL3_OFFSET, {24'h0, c}, `CVD_RESP_OKAY);
         done_pulse();
      end
      pchk(p1, 1'h0);
      repeat (4) begin
         @(posedge aclk);
         #1;
         chk("extra start", 32'h0, {31'h0, conv_start});
      end
      rd(`CVD_CORE_OFFSET, {30'h0, g, 1'h0}, `CVD_RESP_OKAY);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`CVD_CTRL3_OFFSET, 32'h0, `CVD_RESP_OKAY);
      rd(`CVD_CORE_OFFSET, 32'h0, `CVD_RESP_OKAY);
      wr(`CVD_CTRL3_OFFSET, 32'hFFFFFFFF, `CVD_RESP_OKAY);
      rd(`CVD_CTRL3_OFFSET, 32'hC3, `CVD_RESP_OKAY);
      wr(`CVD_CTRL3_OFFSET, 32'h0, `CVD_RESP_OKAY);
      rd(`CVD_CTRL3_OFFSET, 32'h0, `CVD_RESP_OKAY);
      // unmapped place: refused, no effect
      wr(8'h08, 32'hFFFFFFFF, `CVD_RESP_SLVERR);
      rd(8'h08, 32'h0, `CVD_RESP_SLVERR);
      rd(`CVD_CTRL3_OFFSET, 32'h0, `CVD_RESP_OKAY);
      // single mode, invert set but idle
      wr(`CVD_CTRL3_OFFSET, 32'hC2, `CVD_RESP_OKAY);
      conv(1'h0, 1'h1, 3'h7, 3'h7, 8'hC2);
      // pair without inversion
      wr(`CVD_CTRL3_OFFSET, 32'h41, `CVD_RESP_OKAY);
      conv(1'h1, 1'h0, 3'h2, 3'h2, 8'h41);
      // pair with inversion of all three
      wr(`CVD_CTRL3_OFFSET, 32'h83, `CVD_RESP_OKAY);
      conv(1'h1, 1'h1, 3'h5, 3'h2, 8'h83);
      // second reset, after the last pair, clears outputs and ctrl3
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      #1;
      pchk(3'h0, 1'h0);
      rd(`CVD_CTRL3_OFFSET, 32'h0, `CVD_RESP_OKAY);
      results();
   end
endmodule
